//--- pkg/ctl_seq_params.svh
// Notes on behaviour
// R1: reset drops power-stage enable within 370 ns
// R2: host holds reset at least 400 ns
// R3: control bus answers about 3 ms after reset
// R4: 10 ms start-up; audio needs master volume write
// R5: power-down drops enable; 120 ms wake-up
// R6: host gives 5 clocks before power-down release
// R7: power stage holds error at least 350 ns
// R8: back-end error drops enable within 100 us
// R9: error recovery interval programmable 1 to 10 ms
// R10: mute ramp follows programmed slew rate
// R11: host holds headphone select at least 350 ns
// R12: headphone change: soft ramp, then 0.2-1 ms switchover
// R13: volume spans +18 dB to -109 dB, then mute
// R14: no clipping until volume exceeds 0 dB
// R15: supply volume limits modulation to 120..1944 of 2048
// R16: unmute ramps back at same slew rate
// R17: enable stays low until start-up completes
//
// constants of the control-pin sequencer: offsets, fields, timings
// assumes a 20 MHz clock and a 32-bit AHB-Lite register port
`ifndef CTL_SEQ_PARAMS_SVH
`define CTL_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS 50
`define NS_PER_MS 1000000
`define NS_PER_US 1000

`define T_BUS_READY_MS 3
`define T_RESET_RUN_MS 10
`define T_PDN_RUN_MS 120
`define T_SWITCH_US 200
`define T_ERR_OFF_US 100
`define T_STEP_BASE_NS 1000
`define BUS_READY_CYC (`T_BUS_READY_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define RESET_RUN_CYC (`T_RESET_RUN_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define PDN_RUN_CYC (`T_PDN_RUN_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define MS_CYC (`NS_PER_MS / `CLK_PERIOD_NS)
`define SWITCH_CYC \
  ((`T_SWITCH_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_BASE_CYC (`T_STEP_BASE_NS / `CLK_PERIOD_NS)

`define REG_MASTER_VOL 8'h00
`define REG_CHAN_VOL 8'h04
`define REG_SLEW 8'h08
`define REG_RECOVERY 8'h0c
`define REG_SUPPLY_VOL 8'h10
`define REG_STATE 8'h14
`define REG_IRQ_STAT 8'h18
`define REG_IRQ_MASK 8'h1c

`define RST_MASTER_VOL 8'hff
`define RST_CHAN_VOL 8'h24
`define RST_SLEW 8'h00
`define RST_RECOVERY 4'h1
`define RST_SUPPLY_VOL 2'h0

// volume code: 0x00 = +18 dB, 0.5 dB per step, 0xfe = -109 dB, 0xff mute
`define VOL_ZERO_DB 8'h24
`define VOL_MIN_ATTEN 8'hfe
`define VOL_MUTE 8'hff

`define RECOVERY_MIN 4'h1
`define RECOVERY_MAX 4'ha

`define SUPPLY_VOLUME_CONTROL_FULL_MIN 11'h000
`define SUPPLY_VOLUME_CONTROL_FULL_MAX 11'h7ff
`define SUPPLY_VOLUME_CONTROL_24_MIN 11'h078
`define SUPPLY_VOLUME_CONTROL_24_MAX 11'h798
`define SUPPLY_VOLUME_CONTROL_RANGE_24 2'h3

`define IRQ_ERR 0
`define IRQ_RECOVERED 1
`define IRQ_HP_DONE 2
`define IRQ_RUN 3
`define IRQ_BITS 4

`endif

//--- pkg/ctl_seq_pkg.sv
// types of the control-pin sequencer
// assumes ctl_seq_params.svh for all numeric constants
package ctl_seq_pkg;
  typedef enum logic [2:0] {
    PWR_BOOT, PWR_DOWN, PWR_WAKE, PWR_RUN, PWR_FAULT, PWR_RECOVER
  } pwr_state_e;
  typedef enum logic [1:0] {
    HP_IDLE, HP_FADE, HP_SWITCH, HP_RISE
  } hp_state_e;
  typedef logic [7:0] vol_t;
endpackage : ctl_seq_pkg

//--- rtl/control_pin_sequencing.sv
// control-pin sequencer: reset and power-down start-up, back-end error
// recovery, mute and headphone volume ramps, volume and supply limits.
// assumes an AHB-Lite master on the same clock; pins are asynchronous.
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ctl_seq_params.svh"
module control_pin_sequencing import ctl_seq_pkg::*; #(
  parameter int BUS_READY_CYC = `BUS_READY_CYC,
  parameter int RESET_RUN_CYC = `RESET_RUN_CYC,
  parameter int PDN_RUN_CYC = `PDN_RUN_CYC,
  parameter int MS_CYC = `MS_CYC,
  parameter int SWITCH_CYC = `SWITCH_CYC,
  parameter int STEP_BASE = `STEP_BASE_CYC,
  parameter logic [10:0] SUPPLY_VOLUME_CONTROL_12_MIN = 11'h000,
  parameter logic [10:0] SUPPLY_VOLUME_CONTROL_12_MAX = 11'h7ff,
  parameter logic [10:0] SUPPLY_VOLUME_CONTROL_18_MIN = 11'h000,
  parameter logic [10:0] SUPPLY_VOLUME_CONTROL_18_MAX = 11'h7ff
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic powerDownInput,
  input wire logic backendErrorInput,
  input wire logic headphoneSelect,
  input wire logic muteInput,
  output logic powerStageEnable,
  output logic audioEnable,
  output logic headphoneActive,
  output vol_t volumeLevel,
  output logic clipWarning,
  output logic [10:0] supplyVolumeMin,
  output logic [10:0] supplyVolumeMax,
  output logic irq
);
  // pin synchronisers: syncA feeds syncB only
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic pdnSync;
  logic errSync;
  logic hpSync;
  logic muteSync;

  pwr_state_e pwrState;
  hp_state_e hpState;
  logic [21:0] runCnt;
  logic [15:0] msPre;
  logic [3:0] msCnt;
  logic [15:0] busCnt;
  logic busReady;
  logic [11:0] swCnt;
  logic masterSeen;

  logic reqPend;
  logic [7:0] reqAddr;
  logic reqWrite;
  logic doAccess;
  logic doWrite;

  vol_t masterVol;
  vol_t chanVol;
  logic [7:0] slewRate;
  logic [3:0] recoveryMs;
  logic [1:0] supplyRange;
  logic [`IRQ_BITS-1:0] irqStat;
  logic [`IRQ_BITS-1:0] irqMask;
  logic [`IRQ_BITS-1:0] irqEvent;
  logic [`IRQ_BITS-1:0] next_irqStat;

  vol_t rampTarget;
  vol_t rampLevel;
  logic rampSettled;

  // gains add in dB around the 0 dB code; saturates at the +18 dB code,
  // and anything past the last attenuation step is mute
  function automatic vol_t combineVol(input vol_t a, input vol_t b);
    logic [8:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (a == `VOL_MUTE || b == `VOL_MUTE
        || sum > {1'b0, `VOL_MIN_ATTEN} + {1'b0, `VOL_ZERO_DB})
      return `VOL_MUTE; // [R13]
    if (sum < {1'b0, `VOL_ZERO_DB})
      return 8'h00; // [R13]
    return 8'(sum - {1'b0, `VOL_ZERO_DB});
  endfunction : combineVol

  function automatic logic [3:0] clampMs(input logic [3:0] v);
    if (v < `RECOVERY_MIN)
      return `RECOVERY_MIN;
    if (v > `RECOVERY_MAX)
      return `RECOVERY_MAX;
    return v;
  endfunction : clampMs

  assign pdnSync = syncB[0];
  assign errSync = syncB[1];
  assign hpSync = syncB[2];
  assign muteSync = syncB[3];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
    end else begin
      syncA <= {muteInput, headphoneSelect, backendErrorInput,
                powerDownInput};
      syncB <= syncA;
    end
  end

  // control bus held off after reset release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busCnt <= 16'h0000;
      busReady <= 1'b0;
    end else if (!busReady) begin
      busCnt <= busCnt + 16'h0001;
      busReady <= (busCnt == 16'(BUS_READY_CYC - 1)); // [R3]
    end
  end

  // power sequencing; power-down wins over every other state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwrState <= PWR_BOOT;
      runCnt <= 22'h000000;
      msPre <= 16'h0000;
      msCnt <= 4'h0;
    end else if (pdnSync) begin
      pwrState <= PWR_DOWN; // [R5]
      runCnt <= 22'h000000;
    end else begin
      case (pwrState)
        PWR_BOOT: begin
          runCnt <= runCnt + 22'h000001;
          if (runCnt == 22'(RESET_RUN_CYC - 1))
            pwrState <= PWR_RUN; // [R4] [R17]
        end
        PWR_DOWN: begin
          pwrState <= PWR_WAKE;
          runCnt <= 22'h000000;
        end
        PWR_WAKE: begin
          runCnt <= runCnt + 22'h000001;
          if (runCnt == 22'(PDN_RUN_CYC - 1))
            pwrState <= PWR_RUN; // [R5] [R17]
        end
        PWR_RUN: begin
          if (errSync)
            pwrState <= PWR_FAULT; // [R8]
        end
        PWR_FAULT: begin
          // an error has no longest duration: wait until it clears
          msPre <= 16'h0000;
          msCnt <= 4'h0;
          if (!errSync)
            pwrState <= PWR_RECOVER;
        end
        PWR_RECOVER: begin
          if (errSync) begin
            pwrState <= PWR_FAULT;
          end else if (msPre == 16'(MS_CYC - 1)) begin
            msPre <= 16'h0000;
            msCnt <= msCnt + 4'h1;
            if (msCnt + 4'h1 == clampMs(recoveryMs))
              pwrState <= PWR_RUN; // [R9]
          end else begin
            msPre <= msPre + 16'h0001;
          end
        end
        default: pwrState <= PWR_BOOT;
      endcase
    end
  end

  // async reset clears the enable at once, well inside 370 ns
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      powerStageEnable <= 1'b0; // [R1]
      audioEnable <= 1'b0;
    end else begin
      powerStageEnable <= (pwrState == PWR_RUN) && !pdnSync
                          && !errSync; // [R8] [R5] [R17]
      audioEnable <= (pwrState == PWR_RUN) && masterSeen; // [R4]
    end
  end

  // headphone switchover: fade out, wait, switch, fade in
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hpState <= HP_IDLE;
      headphoneActive <= 1'b0;
      swCnt <= 12'h000;
    end else begin
      case (hpState)
        HP_IDLE: begin
          if (hpSync != headphoneActive)
            hpState <= HP_FADE; // [R12]
        end
        HP_FADE: begin
          swCnt <= 12'h000;
          if (rampLevel == `VOL_MUTE)
            hpState <= HP_SWITCH;
        end
        HP_SWITCH: begin
          swCnt <= swCnt + 12'h001;
          if (swCnt == 12'(SWITCH_CYC - 1)) begin
            headphoneActive <= ~headphoneActive; // [R12]
            hpState <= HP_RISE;
          end
        end
        HP_RISE: begin
          if (rampSettled)
            hpState <= HP_IDLE;
        end
        default: hpState <= HP_IDLE;
      endcase
    end
  end

  always_comb begin
    if (muteSync || hpState != HP_IDLE && hpState != HP_RISE
        || !audioEnable)
      rampTarget = `VOL_MUTE; // [R10]
    else
      rampTarget = combineVol(masterVol, chanVol); // [R13] [R16]
  end

  vol_ramp #(.BASE(STEP_BASE)) ramp (
    .clock(clock),
    .rst(rst),
    .target(rampTarget),
    .slew(slewRate),
    .level(rampLevel),
    .settled(rampSettled)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      volumeLevel <= `VOL_MUTE;
      clipWarning <= 1'b0;
      supplyVolumeMin <= `SUPPLY_VOLUME_CONTROL_FULL_MIN;
      supplyVolumeMax <= `SUPPLY_VOLUME_CONTROL_FULL_MAX;
    end else begin
      volumeLevel <= rampLevel;
      clipWarning <= (rampLevel < `VOL_ZERO_DB); // [R14]
      case (supplyRange)
        2'h1: begin
          supplyVolumeMin <= SUPPLY_VOLUME_CONTROL_12_MIN;
          supplyVolumeMax <= SUPPLY_VOLUME_CONTROL_12_MAX;
        end
        2'h2: begin
          supplyVolumeMin <= SUPPLY_VOLUME_CONTROL_18_MIN;
          supplyVolumeMax <= SUPPLY_VOLUME_CONTROL_18_MAX;
        end
        `SUPPLY_VOLUME_CONTROL_RANGE_24: begin
          supplyVolumeMin <= `SUPPLY_VOLUME_CONTROL_24_MIN; // [R15]
          supplyVolumeMax <= `SUPPLY_VOLUME_CONTROL_24_MAX; // [R15]
        end
        default: begin
          supplyVolumeMin <= `SUPPLY_VOLUME_CONTROL_FULL_MIN;
          supplyVolumeMax <= `SUPPLY_VOLUME_CONTROL_FULL_MAX;
        end
      endcase
    end
  end

  // AHB-Lite slave: one wait state, longer until the bus is ready
  assign doAccess = reqPend && busReady; // [R3]
  assign doWrite = doAccess && reqWrite;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reqPend <= 1'b0;
      reqAddr <= 8'h00;
      reqWrite <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (doAccess) begin
      reqPend <= 1'b0;
      hreadyout <= 1'b1;
    end else if (hsel && htrans[1] && hready) begin
      reqPend <= 1'b1;
      reqAddr <= {haddr[7:2], 2'b00};
      reqWrite <= hwrite;
      hreadyout <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (doAccess && !reqWrite) begin
      case (reqAddr)
        `REG_MASTER_VOL: hrdata <= {24'h000000, masterVol};
        `REG_CHAN_VOL: hrdata <= {24'h000000, chanVol};
        `REG_SLEW: hrdata <= {24'h000000, slewRate};
        `REG_RECOVERY: hrdata <= {28'h0000000, recoveryMs};
        `REG_SUPPLY_VOL: hrdata <= {30'h00000000, supplyRange};
        `REG_STATE: hrdata <= {16'h0000, rampLevel, 1'b0, headphoneActive,
                               hpState, pwrState, busReady};
        `REG_IRQ_STAT: hrdata <= {28'h0000000, irqStat};
        `REG_IRQ_MASK: hrdata <= {28'h0000000, irqMask};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      masterVol <= `RST_MASTER_VOL;
      chanVol <= `RST_CHAN_VOL;
      slewRate <= `RST_SLEW;
      recoveryMs <= `RST_RECOVERY;
      supplyRange <= `RST_SUPPLY_VOL;
      irqMask <= '0;
      masterSeen <= 1'b0;
    end else if (doWrite) begin
      case (reqAddr)
        `REG_MASTER_VOL: begin
          masterVol <= hwdata[7:0];
          masterSeen <= 1'b1; // [R4]
        end
        `REG_CHAN_VOL: chanVol <= hwdata[7:0];
        `REG_SLEW: slewRate <= hwdata[7:0]; // [R10]
        `REG_RECOVERY: recoveryMs <= hwdata[3:0]; // [R9]
        `REG_SUPPLY_VOL: supplyRange <= hwdata[1:0];
        `REG_IRQ_MASK: irqMask <= hwdata[`IRQ_BITS-1:0];
        default: masterSeen <= masterSeen;
      endcase
    end
  end

  // sticky events; a new event beats a write-one clear
  always_comb begin
    irqEvent = '0;
    irqEvent[`IRQ_ERR] = (pwrState == PWR_RUN) && errSync;
    irqEvent[`IRQ_RECOVERED] = (pwrState == PWR_RECOVER)
                               && !errSync && msPre == 16'(MS_CYC - 1)
                               && (msCnt + 4'h1 == clampMs(recoveryMs));
    irqEvent[`IRQ_HP_DONE] = (hpState == HP_RISE) && rampSettled;
    irqEvent[`IRQ_RUN] = !pdnSync && runCnt == 22'(PDN_RUN_CYC - 1)
                         && pwrState == PWR_WAKE
                         || !pdnSync && pwrState == PWR_BOOT
                         && runCnt == 22'(RESET_RUN_CYC - 1);
    next_irqStat = irqStat;
    if (doWrite && reqAddr == `REG_IRQ_STAT)
      next_irqStat = irqStat & ~hwdata[`IRQ_BITS-1:0];
    next_irqStat = next_irqStat | irqEvent;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irqStat <= '0;
      irq <= 1'b0;
    end else begin
      irqStat <= next_irqStat;
      irq <= |(next_irqStat & irqMask);
    end
  end
endmodule : control_pin_sequencing

//--- rtl/vol_ramp.sv
// soft volume ramp: steps the level one code toward a target
// assumes target and slew come from logic on the same clock
`timescale 1ns/1ps
`include "ctl_seq_params.svh"
module vol_ramp import ctl_seq_pkg::*; #(
  parameter int BASE = `STEP_BASE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire vol_t target,
  input wire logic [7:0] slew,
  output vol_t level,
  output logic settled
);
  logic [15:0] baseCnt;
  logic [7:0] slewCnt;
  logic step;

  // one step every BASE*(slew+1) cycles, so slew sets the ramp time
  assign step = (baseCnt == 16'(BASE - 1)) && (slewCnt == slew);
  assign settled = (level == target);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      baseCnt <= 16'h0000;
      slewCnt <= 8'h00;
    end else if (baseCnt == 16'(BASE - 1)) begin
      baseCnt <= 16'h0000;
      slewCnt <= (slewCnt >= slew) ? 8'h00 : slewCnt + 8'h01;
    end else begin
      baseCnt <= baseCnt + 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= `VOL_MUTE;
    end else if (step && !settled) begin
      level <= (level < target) ? level + 8'h01 : level - 8'h01; // [R10] [R16]
    end
  end
endmodule : vol_ramp

//--- test/ctl_seq_sva.sv
// checker of the sequencer pins and volume ramp
// assumes binding to control_pin_sequencing
`timescale 1ns/1ps
module ctl_seq_checker import ctl_seq_pkg::*; #(
  parameter int RESET_RUN_CYC = 50
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic powerDownInput,
  input wire logic backendErrorInput,
  input wire logic powerStageEnable,
  input wire logic headphoneActive,
  input wire vol_t volumeLevel,
  input wire logic clipWarning,
  input wire logic [10:0] supplyVolumeMin,
  input wire logic [10:0] supplyVolumeMax
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  int upCnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      upCnt <= 0;
    else if (upCnt < RESET_RUN_CYC)
      upCnt <= upCnt + 1;
  end
  a_err_drop: assert property (
    backendErrorInput [*4] |=> !powerStageEnable)
    else $error("enable high during error");
  a_pdn_drop: assert property (
    powerDownInput [*4] |=> !powerStageEnable)
    else $error("enable high during power down");
  // two clocks of slack: the run edge itself is the designer's choice
  a_boot_quiet: assert property (
    upCnt < RESET_RUN_CYC - 2 |-> !powerStageEnable)
    else $error("enable high during start-up");
  a_clip_flag: assert property (
    $stable(volumeLevel) [*2] |-> clipWarning == (volumeLevel < 8'h24))
    else $error("clip flag wrong");
  a_vol_step: assert property (
    $changed(volumeLevel) |->
    (volumeLevel - $past(volumeLevel)) inside {8'h01, 8'hff})
    else $error("volume jumped");
  a_ramp_pace: assert property (
    $changed(volumeLevel) |=> $stable(volumeLevel))
    else $error("volume stepped too fast");
  a_hp_muted: assert property (
    $changed(headphoneActive) |-> volumeLevel == 8'hff)
    else $error("switchover while audible");
  a_supply_pair: assert property (
    supplyVolumeMin == (supplyVolumeMax == 11'h798 ? 11'h078 : 11'h000))
    else $error("supply limits inconsistent");
endmodule : ctl_seq_checker
bind control_pin_sequencing ctl_seq_checker #(
  .RESET_RUN_CYC(RESET_RUN_CYC)
) i_chk (.clock, .rst, .powerDownInput, .backendErrorInput,
  .powerStageEnable, .headphoneActive, .volumeLevel, .clipWarning,
  .supplyVolumeMin, .supplyVolumeMax);

//--- test/power_stage_model.sv
// power stage: answers a fault request with an error pulse
// assumes the bench raises fault for one clock per event
`timescale 1ns/1ps
module power_stage_model #(
  parameter int HOLD = 8
) (
  input wire logic clock,
  input wire logic fault,
  output logic errorOut
);
  int cnt = 0;
  always @(posedge clock) begin
    if (fault && cnt == 0)
      cnt <= HOLD;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // 8 clocks is 400 ns, so the pulse is never too short to count
  assign errorOut = (cnt > 0);
endmodule : power_stage_model

//--- test/testbench.sv
// bench: random and corner scenarios on the sequencer, self-checking
// assumes the shortened timing parameters given at i_dut
`timescale 1ns/1ps
module testbench import ctl_seq_pkg::*;;
  logic clock = 0, rst = 1, hsel = 0, hwrite = 0, muteInput = 0;
  logic powerDownInput = 0, headphoneSelect = 0, faultReq = 0, b;
  logic [31:0] haddr = 0, hwdata = 0, q, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, powerStageEnable, audioEnable, irq;
  logic headphoneActive, clipWarning, backendErrorInput;
  logic [10:0] supplyVolumeMin, supplyVolumeMax;
  vol_t volumeLevel, ev;
  int err_count = 0, n_tests = 0, n, t0, s, cyc = 0;
  logic [7:0] regA [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h40};
  logic [31:0] regE [5] = '{32'h24, 0, 1, 0, 0};
  int recA [4] = '{0, 3, 10, 15};
  int recE [4] = '{1, 3, 10, 10};
  control_pin_sequencing #(.BUS_READY_CYC(20), .RESET_RUN_CYC(50),
    .PDN_RUN_CYC(60), .MS_CYC(10), .STEP_BASE(2)
  ) i_dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .powerDownInput, .backendErrorInput, .headphoneSelect, .muteInput,
    .powerStageEnable, .audioEnable, .headphoneActive, .volumeLevel,
    .clipWarning, .supplyVolumeMin, .supplyVolumeMax, .irq);
  power_stage_model i_stage (.clock, .fault(faultReq),
    .errorOut(backendErrorInput));
  always #25 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chkr(input int g, input int lo, input int hi);
    n_tests++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("[FAIL] t=%0t got %h want %h..%h", $time, g, lo, hi);
    end
  endtask : chkr
  // expected combined code: dB add around 0x24, +18 dB cap, mute past fe
  function automatic vol_t expVol(input int a, input int b);
    int g;
    g = a + b - 'h24;
    if (a == 'hff || b == 'hff || g > 'hfe)
      return 8'hff;
    return (g < 0) ? 8'h00 : 8'(g);
  endfunction : expVol
  // no wait limit here: a stalled slave is cut short by the watchdog
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic waitEn(input logic v, output int k);
    k = 0;
    while (powerStageEnable !== v) begin
      @(posedge clock);
      k++;
    end
  endtask : waitEn
  task automatic stepGap(output int g);
    vol_t v;
    v = volumeLevel;
    g = 0;
    while (volumeLevel === v && g < 99) begin
      @(posedge clock);
      g++;
    end
    v = volumeLevel;
    g = 0;
    while (volumeLevel === v && g < 99) begin
      @(posedge clock);
      g++;
    end
  endtask : stepGap
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    #3000000;
    err_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(52000));
    repeat (9) @(posedge clock);
    chk({hreadyout, powerStageEnable, irq, volumeLevel}, 32'h4ff);
    rst <= 0;
    t0 = cyc;
    bus(1, 8'h00, 32'h24);
    chkr(cyc - t0, 20, 49);
    waitEn(1, n);
    chkr(cyc - t0, 48, 60);
    repeat (2) @(posedge clock);
    chk(audioEnable, 1);
    foreach (regA[i]) begin
      bus(0, regA[i], 0);
      chk(q, regE[i]);
      chk(hresp, 0);
    end
    bus(0, 8'h14, 0);
    chk(q[7:0], {4'h0, PWR_RUN, 1'b1});
    for (int r = 0; r < 3; r++) begin
      bus(1, 8'h10, r);
      repeat (2) @(posedge clock);
      chk({supplyVolumeMin, supplyVolumeMax}, {11'h000, 11'h7ff});
    end
    bus(1, 8'h10, 3);
    repeat (2) @(posedge clock);
    chk({supplyVolumeMin, supplyVolumeMax}, {11'h078, 11'h798});
    bus(1, 8'h04, 0);
    bus(1, 8'h00, 0);
    repeat (400) @(posedge clock);
    chk(clipWarning, 1);
    // corners at the last attenuation step, then a random pair
    for (int i = 0; i < 3; i++) begin
      n = (i < 2) ? 'hfe : $urandom % 256;
      s = (i < 2) ? 'h25 - i : $urandom % 256;
      bus(1, 8'h04, n);
      bus(1, 8'h00, s);
      repeat (600) @(posedge clock);
      ev = expVol(s, n);
      chk({clipWarning, volumeLevel}, {ev < 8'h24, ev});
    end
    bus(1, 8'h04, 32'h24);
    bus(1, 8'h00, 32'h24);
    repeat (400) @(posedge clock);
    chk({clipWarning, volumeLevel}, 9'h024);
    repeat (3) begin
      s = $urandom % 4;
      bus(1, 8'h08, s);
      muteInput <= 1;
      stepGap(n);
      chkr(n, 2 * (s + 1), 2 * (s + 1));
      while (volumeLevel !== 8'hff) @(posedge clock);
      muteInput <= 0;
      stepGap(n);
      chkr(n, 2 * (s + 1), 2 * (s + 1));
      while (volumeLevel !== 8'h24) @(posedge clock);
    end
    foreach (recA[i]) begin
      bus(1, 8'h0c, recA[i]);
      faultReq <= 1;
      @(posedge clock);
      faultReq <= 0;
      waitEn(0, n);
      chkr(n, 0, 2000);
      while (backendErrorInput) @(posedge clock);
      waitEn(1, n);
      chkr(n, recE[i] * 15 / 2, recE[i] * 25 / 2 + 4);
    end
    bus(0, 8'h18, 0);
    chk(q[1:0], 2'h3);
    bus(1, 8'h1c, 0);
    repeat (2) @(posedge clock);
    b = irq;
    bus(1, 8'h1c, 32'hf);
    repeat (2) @(posedge clock);
    chk(b ^ irq, 1);
    bus(1, 8'h18, 32'hf);
    repeat (2) @(posedge clock);
    chk(irq, 0);
    powerDownInput <= 1;
    waitEn(0, n);
    chkr(n, 0, 6000);
    repeat (8) @(posedge clock);
    powerDownInput <= 0;
    waitEn(1, n);
    chkr(n, 60, 70);
    repeat (2) begin
      headphoneSelect <= !headphoneSelect;
      n = 0;
      @(posedge clock);
      while (headphoneActive !== headphoneSelect) begin
        @(posedge clock);
        n += (volumeLevel === 8'hff);
      end
      // 0.2 to 1 ms of silence at 50 ns per cycle
      chkr(n, 4000, 20000);
    end
    @(posedge clock);
    rst <= 1;
    #370;
    chk(powerStageEnable, 0);
    end_of_test();
  end
endmodule : testbench
